// >>> smp_pkg.sv
// Constants and types for the command message parser
// What this block does
// - Colon descends one header level
// - After semicolon, resolve at previous level
// - Colon after semicolon returns path to root
// - Line feed, end flag or CR LF terminate
// - Terminator resets path to root, except inside block data where line feed and end flag are data
// - Host sends optional nodes in compound messages
// - Missing optional parameter is ignored
// - Channel list in parentheses with at-sign, six max
// - Channel results in list order
// - Channel list glued to query marker: error -103
// - Numbers with sign, point, exponent accepted
// - MIN and MAX tokens accepted as numbers
// - Unit suffix accepted after a number
// - Discrete words matched case-insensitively
// - Boolean OFF/0 false, ON/1 true
// - Quoted strings, doubled quote is literal
// - Block data passes any 8-bit byte
// - Device clear aborts, idles, flushes buffers
// - Device clear keeps status, errors, settings
// - Calibration tally steps once per cycle with a save, password change or firmware update
// - Unread reply on new command: query interrupted
// - Headers full or short form, any case
// - Question mark makes a query
package smp_pkg;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_DQ = 8'h22;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_SQ = 8'h27;
  localparam logic [7:0] CH_LPAR = 8'h28;
  localparam logic [7:0] CH_RPAR = 8'h29;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [3:0] MAX_CHANS = 4'h6;
  localparam int FIFO_DEPTH = 32;
  // Error codes reported to the error queue
  localparam logic signed [15:0] ERR_SEPARATOR = -16'sd103;
  localparam logic signed [15:0] ERR_HEADER = -16'sd113;
  localparam logic signed [15:0] ERR_QUERY_INT = -16'sd410;
  localparam logic signed [15:0] ERR_CHANLIST = -16'sd108;
  // Token kinds emitted to the command executor
  typedef enum logic [3:0] {
    SMP_TOK_HEADER = 4'h0,
    SMP_TOK_NUMBER = 4'h1,
    SMP_TOK_WORD = 4'h2,
    SMP_TOK_STRING = 4'h3,
    SMP_TOK_CHAN = 4'h4,
    SMP_TOK_BLOCK = 4'h5,
    SMP_TOK_QUERY = 4'h6,
    SMP_TOK_END_CMD = 4'h7,
    SMP_TOK_END_MSG = 4'h8
  } smp_tok_t;
  // Gray path along header, parameters, end
  typedef enum logic [3:0] {
    SMP_ST_IDLE = 4'b0000,
    SMP_ST_HDR = 4'b0001,
    SMP_ST_QMARK = 4'b0011,
    SMP_ST_PGAP = 4'b0010,
    SMP_ST_PARAM = 4'b0110,
    SMP_ST_STR = 4'b0111,
    SMP_ST_STRQ = 4'b0101,
    SMP_ST_CHAN = 4'b0100,
    SMP_ST_BLKN = 4'b1100,
    SMP_ST_BLKL = 4'b1101,
    SMP_ST_BLKD = 4'b1111,
    SMP_ST_CR = 4'b1110,
    SMP_ST_SKIP = 4'b1010
  } smp_state_t;
endpackage : smp_pkg

// >>> smp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module smp_fifo
  import smp_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;
  assign out_valid = wr_ptr != rd_ptr;
  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    // Flush empties both ends at once
    if (flush)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end
    else
    begin
      if (do_wr)
        next_wr_ptr = wr_ptr + 1'b1;
      if (do_rd)
        next_rd_ptr = rd_ptr + 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (do_wr && !flush)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : smp_fifo

// >>> smp_parser.sv
// Byte-level command message parser with token output
`timescale 1ns/10ps
module smp_parser
  import smp_pkg::*;
#(
  parameter int DEPTH_LEVELS = 8,
  parameter int CNT_W = 16
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_byte,
  input wire logic in_end,
  input wire logic device_clear,
  input wire logic hdr_known,
  input wire logic [1:0] param_cls,
  input wire logic reply_pending,
  input wire logic cal_saved,
  input wire logic cal_pass_changed,
  input wire logic fw_updated,
  output logic tok_valid,
  input wire logic tok_ready,
  output logic [3:0] tok_kind,
  output logic [7:0] tok_char,
  output logic [2:0] tok_level,
  output logic err_valid,
  output logic signed [15:0] err_code,
  output logic abort_meas,
  output logic flush_out,
  output logic [CNT_W-1:0] cal_tally,
  output logic [2:0] path_level,
  output logic is_query
);
  initial
  begin
    if (DEPTH_LEVELS < 2 || DEPTH_LEVELS > 8)
      $error("DEPTH_LEVELS must be 2..8");
  end
  // Upper-case fold makes header and word matching case-blind
  function automatic logic [7:0] smp_upper(input logic [7:0] c);
    smp_upper = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
  endfunction : smp_upper
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] cur_byte;
  logic cur_end;
  logic [8:0] fifo_out;
  smp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(device_clear),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_end, in_byte}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out)
  );
  assign cur_byte = fifo_out[7:0];
  assign cur_end = fifo_out[8];
  smp_state_t state;
  smp_state_t next_state;
  logic [2:0] level;
  logic [2:0] next_level;
  logic after_semi;
  logic next_after_semi;
  logic query;
  logic next_query;
  logic [7:0] quote;
  logic [7:0] next_quote;
  logic [3:0] chans;
  logic [3:0] next_chans;
  logic [3:0] blk_digits;
  logic [3:0] next_blk_digits;
  logic [31:0] blk_len;
  logic [31:0] next_blk_len;
  logic [CNT_W-1:0] next_cal_tally;
  logic next_tok_valid;
  logic [3:0] next_tok_kind;
  logic [7:0] next_tok_char;
  logic [2:0] next_tok_level;
  logic next_err_valid;
  logic signed [15:0] next_err_code;
  logic take;
  logic term;
  // Hold the byte while the token slot is still full
  assign fifo_ready = !tok_valid || tok_ready;
  assign take = fifo_valid && fifo_ready && !device_clear;
  assign term = cur_end || cur_byte == CH_LF;
  assign path_level = level;
  assign is_query = query;
  assign abort_meas = device_clear;
  assign flush_out = device_clear;
  always_comb
  begin
    next_state = state;
    next_level = level;
    next_after_semi = after_semi;
    next_query = query;
    next_quote = quote;
    next_chans = chans;
    next_blk_digits = blk_digits;
    next_blk_len = blk_len;
    next_tok_valid = tok_valid && !tok_ready;
    next_tok_kind = tok_kind;
    next_tok_char = tok_char;
    next_tok_level = tok_level;
    next_err_valid = 1'b0;
    next_err_code = err_code;
    next_cal_tally = cal_tally;
    if (cal_saved || cal_pass_changed || fw_updated)
      next_cal_tally = cal_tally + 1'b1;
    if (device_clear)
    begin
      // Only parse state; tally and error log untouched
      next_state = SMP_ST_IDLE;
      next_level = '0;
      next_after_semi = 1'b0;
      next_query = 1'b0;
      next_tok_valid = 1'b0;
    end
    else if (take)
    begin
      next_tok_valid = 1'b1;
      next_tok_char = cur_byte;
      next_tok_level = level;
      next_tok_kind = SMP_TOK_HEADER;
      if (term && state != SMP_ST_BLKD)
      begin
        next_state = SMP_ST_IDLE;
        next_level = '0;
        next_after_semi = 1'b0;
        next_query = 1'b0;
        next_tok_kind = SMP_TOK_END_MSG;
      end
      else
      begin
        case (state)
          SMP_ST_IDLE, SMP_ST_HDR:
          begin
            if (state == SMP_ST_IDLE && reply_pending)
            begin
              next_err_valid = 1'b1;
              next_err_code = ERR_QUERY_INT;
            end
            if (cur_byte == CH_COLON)
            begin
              next_tok_valid = 1'b0;
              if (state == SMP_ST_IDLE && after_semi)
                next_level = '0;
              else if (state == SMP_ST_HDR && level < 3'(DEPTH_LEVELS - 1))
                next_level = level + 1'b1;
              next_state = SMP_ST_HDR;
            end
            else if (cur_byte == CH_QUERY)
            begin
              next_query = 1'b1;
              next_tok_kind = SMP_TOK_QUERY;
              next_state = SMP_ST_QMARK;
            end
            else if (cur_byte == CH_SP)
            begin
              next_tok_valid = 1'b0;
              next_state = SMP_ST_PGAP;
            end
            else if (cur_byte == CH_SEMI)
            begin
              next_tok_kind = SMP_TOK_END_CMD;
              next_after_semi = 1'b1;
              next_state = SMP_ST_IDLE;
            end
            else if (cur_byte == CH_CR)
            begin
              next_tok_valid = 1'b0;
              next_state = SMP_ST_CR;
            end
            else
            begin
              // Level after semicolon stays at previous command's level
              next_tok_char = smp_upper(cur_byte);
              if (state == SMP_ST_IDLE)
                next_after_semi = 1'b0;
              next_state = SMP_ST_HDR;
            end
          end
          SMP_ST_QMARK:
          begin
            next_tok_valid = 1'b0;
            if (cur_byte == CH_SP)
              next_state = SMP_ST_PGAP;
            else if (cur_byte == CH_LPAR)
            begin
              next_err_valid = 1'b1;
              next_err_code = ERR_SEPARATOR;
              next_state = SMP_ST_SKIP;
            end
            else if (cur_byte == CH_SEMI)
            begin
              next_tok_valid = 1'b1;
              next_tok_kind = SMP_TOK_END_CMD;
              next_after_semi = 1'b1;
              next_query = 1'b0;
              next_state = SMP_ST_IDLE;
            end
            else if (cur_byte == CH_CR)
              next_state = SMP_ST_CR;
          end
          SMP_ST_PGAP, SMP_ST_PARAM:
          begin
            next_tok_valid = 1'b0;
            if (cur_byte == CH_SP || cur_byte == CH_COMMA)
              next_state = SMP_ST_PGAP;
            else if (cur_byte == CH_DQ || cur_byte == CH_SQ)
            begin
              next_quote = cur_byte;
              next_state = SMP_ST_STR;
            end
            else if (cur_byte == CH_LPAR)
            begin
              next_chans = '0;
              next_state = SMP_ST_CHAN;
            end
            else if (cur_byte == CH_HASH)
              next_state = SMP_ST_BLKN;
            else if (cur_byte == CH_SEMI)
            begin
              next_tok_valid = 1'b1;
              next_tok_kind = SMP_TOK_END_CMD;
              next_after_semi = 1'b1;
              next_query = 1'b0;
              next_state = SMP_ST_IDLE;
            end
            else if (cur_byte == CH_CR)
              next_state = SMP_ST_CR;
            else
            begin
              // Digits, sign, point, exponent, MIN/MAX, units, ON/OFF
              next_tok_valid = 1'b1;
              next_tok_char = smp_upper(cur_byte);
              next_tok_kind = (param_cls == 2'd0) ? SMP_TOK_NUMBER : SMP_TOK_WORD;
              next_state = SMP_ST_PARAM;
            end
          end
          SMP_ST_STR:
          begin
            if (cur_byte == quote)
            begin
              next_tok_valid = 1'b0;
              next_state = SMP_ST_STRQ;
            end
            else
              next_tok_kind = SMP_TOK_STRING;
          end
          SMP_ST_STRQ:
          begin
            if (cur_byte == quote)
            begin
              next_tok_kind = SMP_TOK_STRING;
              next_state = SMP_ST_STR;
            end
            else
            begin
              next_tok_valid = 1'b0;
              next_state = (cur_byte == CH_SEMI) ? SMP_ST_IDLE : SMP_ST_PGAP;
              next_after_semi = cur_byte == CH_SEMI;
            end
          end
          SMP_ST_CHAN:
          begin
            next_tok_kind = SMP_TOK_CHAN;
            if (cur_byte == CH_RPAR)
              next_state = SMP_ST_PARAM;
            else if (cur_byte >= 8'h30 && cur_byte <= 8'h39)
            begin
              next_chans = chans + 1'b1;
              if (chans >= MAX_CHANS)
              begin
                next_err_valid = 1'b1;
                next_err_code = ERR_CHANLIST;
                next_state = SMP_ST_SKIP;
              end
            end
            else if (cur_byte != CH_AT && cur_byte != CH_COMMA && cur_byte != CH_COLON)
              next_tok_valid = 1'b0;
          end
          SMP_ST_BLKN:
          begin
            next_tok_valid = 1'b0;
            next_blk_digits = cur_byte[3:0];
            next_blk_len = '0;
            next_state = SMP_ST_BLKL;
          end
          SMP_ST_BLKL:
          begin
            next_tok_valid = 1'b0;
            next_blk_len = blk_len * 10 + 32'(cur_byte[3:0]);
            next_blk_digits = blk_digits - 1'b1;
            if (blk_digits == 4'h1)
              next_state = SMP_ST_BLKD;
          end
          SMP_ST_BLKD:
          begin
            // Raw bytes: line feed inside block is data
            next_tok_kind = SMP_TOK_BLOCK;
            next_blk_len = blk_len - 1'b1;
            if (blk_len <= 32'h1)
              next_state = SMP_ST_PARAM;
          end
          SMP_ST_CR:
          begin
            next_tok_valid = 1'b0;
            next_state = SMP_ST_SKIP;
          end
          default:
            next_tok_valid = 1'b0;
        endcase
        if (state == SMP_ST_HDR && !hdr_known && cur_byte != CH_COLON
            && cur_byte != CH_QUERY && cur_byte != CH_SEMI)
        begin
          next_err_valid = 1'b1;
          next_err_code = ERR_HEADER;
          next_tok_valid = 1'b0;
          next_state = SMP_ST_SKIP;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= SMP_ST_IDLE;
      level <= '0;
      after_semi <= 1'b0;
      query <= 1'b0;
      quote <= '0;
      chans <= '0;
      blk_digits <= '0;
      blk_len <= '0;
      cal_tally <= '0;
      tok_valid <= 1'b0;
      tok_kind <= '0;
      tok_char <= '0;
      tok_level <= '0;
      err_valid <= 1'b0;
      err_code <= '0;
    end
    else
    begin
      state <= next_state;
      level <= next_level;
      after_semi <= next_after_semi;
      query <= next_query;
      quote <= next_quote;
      chans <= next_chans;
      blk_digits <= next_blk_digits;
      blk_len <= next_blk_len;
      cal_tally <= next_cal_tally;
      tok_valid <= next_tok_valid;
      tok_kind <= next_tok_kind;
      tok_char <= next_tok_char;
      tok_level <= next_tok_level;
      err_valid <= next_err_valid;
      err_code <= next_err_code;
    end
  end
  terminator_root_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && term && state != SMP_ST_BLKD |=> level == 3'h0 && tok_kind == SMP_TOK_END_MSG)
    else $error("Terminator did not return path to root");
  colon_descend_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !term && state == SMP_ST_HDR && cur_byte == CH_COLON && hdr_known
    && level < 3'(DEPTH_LEVELS - 1) |=> level == $past(level) + 3'h1)
    else $error("Colon did not descend a level");
  root_spec_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !term && state == SMP_ST_IDLE && after_semi && cur_byte == CH_COLON |=> level == 3'h0)
    else $error("Root specifier ignored");
  semi_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !term && state == SMP_ST_HDR && cur_byte == CH_SEMI
    |=> level == $past(level) && after_semi)
    else $error("Semicolon lost the path level");
  sep_error_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !term && state == SMP_ST_QMARK && cur_byte == CH_LPAR
    |=> err_valid && err_code == ERR_SEPARATOR)
    else $error("Missing -103 separator error");
  clear_flush_a: assert property (@(posedge clk_sys) disable iff (rst)
    device_clear |=> state == SMP_ST_IDLE && !tok_valid && !fifo_valid)
    else $error("Device clear did not flush");
  clear_tally_a: assert property (@(posedge clk_sys) disable iff (rst)
    device_clear && !cal_saved && !cal_pass_changed && !fw_updated |=> $stable(cal_tally))
    else $error("Device clear changed the tally");
  tally_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    cal_saved |=> cal_tally == $past(cal_tally) + 1'b1)
    else $error("Calibration tally did not step");
  query_mark_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !term && state == SMP_ST_HDR && hdr_known && cur_byte == CH_QUERY
    |=> query && tok_kind == SMP_TOK_QUERY)
    else $error("Question mark did not make a query");
endmodule : smp_parser

// >>> smp_host.sv
// Host model that sends command bytes to the parser
`timescale 1ns/10ps
module smp_host (
  input wire logic clk_sys,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic in_end
);
  int gap = 0;
  bit hung = 1'b0;
  initial
  begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    in_end = 1'b0;
  end
  // Byte held until taken; idle data is inverted so no stale copy passes
  task automatic send_str(input string s, input logic eoi);
    int n;
    for (int i = 0; i < s.len(); i++)
    begin
      in_valid = 1'b1;
      in_byte = s[i];
      in_end = eoi && (i == s.len() - 1);
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end
      while (in_ready !== 1'b1 && n < 200);
      hung = hung || (n >= 200);
      #1;
      if (gap > 0)
      begin
        in_valid = 1'b0;
        in_byte = ~in_byte;
        repeat (gap) @(posedge clk_sys);
        #1;
      end
    end
    in_valid = 1'b0;
    in_byte = ~in_byte;
    in_end = 1'b0;
  endtask : send_str
  // Pushes one letter per cycle until refused
  task automatic fill(output int n);
    n = 0;
    in_valid = 1'b1;
    in_byte = 8'h41;
    while (n < 40)
    begin
      @(posedge clk_sys);
      if (in_ready !== 1'b1)
        break;
      n++;
    end
    #1;
    in_valid = 1'b0;
    in_byte = 8'hbe;
  endtask : fill
endmodule : smp_host

// >>> scpi_message_parser_test.sv
// Self-checking bench for the command message parser
`timescale 1ns/10ps
module scpi_message_parser_test;
  import smp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic device_clear = 1'b0;
  logic hdr_known = 1'b1;
  logic [1:0] param_cls = 2'h0;
  logic reply_pending = 1'b0;
  logic cal_saved = 1'b0;
  logic cal_pass_changed = 1'b0;
  logic fw_updated = 1'b0;
  logic tok_ready = 1'b1;
  logic in_valid, in_ready, in_end, tok_valid, err_valid, abort_meas, flush_out, is_query;
  logic [7:0] in_byte, tok_char;
  logic [3:0] tok_kind;
  logic [2:0] tok_level, path_level;
  logic signed [15:0] err_code;
  logic [15:0] cal_tally;
  logic [3:0] kq[$];
  logic [7:0] cq[$];
  logic [2:0] lq[$];
  logic [15:0] eq[$];
  bit seen_query = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  smp_host host (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .in_byte(in_byte), .in_end(in_end));
  smp_parser dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .in_byte(in_byte), .in_end(in_end), .device_clear(device_clear), .hdr_known(hdr_known),
    .param_cls(param_cls), .reply_pending(reply_pending), .cal_saved(cal_saved),
    .cal_pass_changed(cal_pass_changed), .fw_updated(fw_updated), .tok_valid(tok_valid),
    .tok_ready(tok_ready), .tok_kind(tok_kind), .tok_char(tok_char), .tok_level(tok_level),
    .err_valid(err_valid), .err_code(err_code), .abort_meas(abort_meas),
    .flush_out(flush_out), .cal_tally(cal_tally), .path_level(path_level),
    .is_query(is_query));
  always @(posedge clk_sys)
  begin
    if (tok_valid === 1'b1 && tok_ready === 1'b1)
    begin
      kq.push_back(tok_kind);
      cq.push_back(tok_char);
      lq.push_back(tok_level);
    end
    if (err_valid === 1'b1)
      eq.push_back(err_code);
    if (is_query === 1'b1)
      seen_query = 1'b1;
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] cnt(input logic [3:0] k, input logic [7:0] c, input bit any);
    cnt = 16'h0;
    foreach (kq[i])
      if (kq[i] === k && (any || cq[i] === c))
        cnt++;
  endfunction : cnt
  function automatic logic [15:0] lvl(input logic [7:0] c);
    lvl = 16'hffff;
    foreach (kq[i])
      if (kq[i] === SMP_TOK_HEADER && cq[i] === c && lvl === 16'hffff)
        lvl = {13'h0, lq[i]};
  endfunction : lvl
  function automatic logic [15:0] errs(input logic [15:0] code);
    errs = 16'h0;
    foreach (eq[i])
      if (eq[i] === code)
        errs++;
  endfunction : errs
  function automatic logic [23:0] chans();
    chans = 24'h0;
    foreach (kq[i])
      if (kq[i] === SMP_TOK_CHAN && cq[i] >= 8'h30 && cq[i] <= 8'h39)
        chans = {chans[15:0], cq[i]};
  endfunction : chans
  task automatic clr;
    kq.delete();
    cq.delete();
    lq.delete();
    eq.delete();
    seen_query = 1'b0;
  endtask : clr
  // Waits for the end-of-message token; a hang ends the run
  task automatic msg(input string s, input logic e);
    logic [15:0] k0;
    int n;
    k0 = cnt(SMP_TOK_END_MSG, 8'h00, 1'b1);
    host.send_str(s, e);
    n = 0;
    while (cnt(SMP_TOK_END_MSG, 8'h00, 1'b1) === k0 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    if (n >= 300 || host.hung)
    begin
      fail_count++;
      $display("MISMATCH at %0t: message did not finish", $time);
      results();
    end
  endtask : msg
  task automatic t_path;
    clr();
    msg("outp:prot;coup;:stat\n", 1'b0);
    check(lvl(8'h4f), 16'h0, "top header level");
    check(lvl(8'h52), 16'h1, "level after colon");
    check(lvl(8'h43), 16'h1, "sibling after semicolon");
    check(lvl(8'h53), 16'h0, "root specifier");
    check({13'h0, path_level}, 16'h0, "path at rest");
    clr();
    msg("outp:prot\n", 1'b0);
    msg("coup\n", 1'b0);
    check(lvl(8'h43), 16'h0, "path after terminator");
  endtask : t_path
  task automatic t_term;
    clr();
    host.gap = 2;
    msg("v\r\n", 1'b0);
    host.gap = 0;
    msg("v", 1'b1);
    check(cnt(SMP_TOK_END_MSG, 8'h00, 1'b1), 16'h2, "terminators");
    check(cnt(SMP_TOK_HEADER, 8'h0d, 1'b0), 16'h0, "return char not header");
  endtask : t_term
  task automatic t_chan;
    clr();
    msg("volt? (@3,1:2)\n", 1'b0);
    check({15'h0, seen_query}, 16'h1, "query flagged");
    check(16'(eq.size()), 16'h0, "spaced list");
    check(chans() === 24'h333132, 1'b1, "channel order");
    clr();
    msg("volt? (@1,2,3,4,5,6)\n", 1'b0);
    check(16'(eq.size()), 16'h0, "six channels");
    msg("volt? (@1,2,3,4,5,6,7)\n", 1'b0);
    check(errs(ERR_CHANLIST), 16'h1, "seven channels");
    clr();
    msg("volt?(@1)\n", 1'b0);
    check(errs(ERR_SEPARATOR), 16'h1, "glued list");
  endtask : t_chan
  task automatic t_param;
    clr();
    param_cls = 2'h1;
    msg("outp On,'a''b'\n", 1'b0);
    param_cls = 2'h0;
    check(cnt(SMP_TOK_WORD, 8'h4e, 1'b0), 16'h1, "word upper case");
    check(cnt(SMP_TOK_STRING, 8'h00, 1'b1), 16'h3, "doubled quote");
    clr();
    msg("volt -1.5e2V\n", 1'b0);
    msg("volt\n", 1'b0);
    msg("volt mAx\n", 1'b0);
    check(16'(eq.size()), 16'h0, "number forms");
    check(cnt(SMP_TOK_NUMBER, 8'h4d, 1'b0), 16'h1, "max token");
    check(cnt(SMP_TOK_NUMBER, 8'h00, 1'b1) > 0, 1'b1, "number tokens");
    clr();
    msg("outp #12\n\377\n", 1'b0);
    check(cnt(SMP_TOK_BLOCK, 8'h0a, 1'b0), 16'h1, "block line feed");
    check(cnt(SMP_TOK_BLOCK, 8'hff, 1'b0), 16'h1, "block high byte");
    check(cnt(SMP_TOK_END_MSG, 8'h00, 1'b1), 16'h1, "one end");
  endtask : t_param
  task automatic t_fault;
    clr();
    hdr_known = 1'b0;
    msg("xyz 1\n", 1'b0);
    hdr_known = 1'b1;
    check(errs(ERR_HEADER), 16'h1, "unknown header");
    clr();
    reply_pending = 1'b1;
    msg("v\n", 1'b0);
    reply_pending = 1'b0;
    check(errs(ERR_QUERY_INT), 16'h1, "reply not read");
  endtask : t_fault
  task automatic t_clear;
    logic [15:0] t0;
    clr();
    t0 = cal_tally;
    tok_ready = 1'b0;
    host.send_str("outp", 1'b0);
    device_clear = 1'b1;
    #1;
    check({14'h0, abort_meas, flush_out}, 16'h3, "clear actions");
    @(posedge clk_sys);
    #1;
    device_clear = 1'b0;
    tok_ready = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check(16'(kq.size()), 16'h0, "input flushed");
    check(cal_tally, t0, "tally kept");
    msg("v\n", 1'b0);
    check(cnt(SMP_TOK_HEADER, 8'h56, 1'b0), 16'h1, "ready again");
    cal_saved = 1'b1;
    @(posedge clk_sys);
    #1;
    cal_saved = 1'b0;
    cal_pass_changed = 1'b1;
    @(posedge clk_sys);
    #1;
    cal_pass_changed = 1'b0;
    fw_updated = 1'b1;
    @(posedge clk_sys);
    #1;
    fw_updated = 1'b0;
    @(posedge clk_sys);
    #1;
    check(cal_tally, t0 + 16'h3, "tally steps");
  endtask : t_clear
  // Executor stalls while the buffer fills
  task automatic t_fill;
    int n;
    int w;
    clr();
    tok_ready = 1'b0;
    host.fill(n);
    // First byte waits in the token slot, so one more than the buffer
    check(16'(n), 16'(FIFO_DEPTH + 1), "bytes before refusal");
    tok_ready = 1'b1;
    w = 0;
    while (kq.size() < n && w < 200)
    begin
      @(posedge clk_sys);
      w++;
    end
    #1;
    check(16'(kq.size()), 16'(FIFO_DEPTH + 1), "drained count");
    if (w >= 200)
    begin
      fail_count++;
      $display("MISMATCH at %0t: buffer did not drain", $time);
      results();
    end
    msg("\n", 1'b0);
  endtask : t_fill
  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_path();
    t_term();
    t_chan();
    t_param();
    t_fault();
    t_clear();
    t_fill();
    results();
  end
endmodule : scpi_message_parser_test
